// File: include/sr_access_pkg.sv
/*
  Package for the status-register access link: opcodes, register indexes,
  bit counts and the host controller's register map.
  Assumes a single-lane serial link in clock mode 0 (sample on rising edge).
*/
package sr_access_pkg;
  // Opcodes
  localparam logic [7:0] OP_READ_INDIRECT = 8'h65;
  localparam logic [7:0] OP_WRITE_SR1 = 8'h01;
  localparam logic [7:0] OP_WRITE_SR2 = 8'h31;
  localparam logic [7:0] OP_WRITE_SR3 = 8'h11;
  localparam logic [7:0] OP_VOLATILE_WE = 8'h50;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  // Status register indexes
  localparam logic [7:0] IDX_SR_ONE = 8'h01;
  localparam logic [7:0] IDX_SR_FIVE = 8'h05;
  // Bit position of the write-enable latch in the first status register
  localparam int WEL_BIT = 1;
  // Reset value of every status register
  localparam logic [7:0] SR_RESET = 8'h00;
  // Undefined data for unimplemented addresses
  localparam logic [7:0] SR_UNDEF = 8'hFF;
  // Bit counts in a transaction
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Host register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_TXDATA = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_RXDATA = 4'hC;
  // Control fields
  localparam int CTRL_START = 0;
  localparam int CTRL_LAST = 1;
  // Serial clock half period in reference clock cycles, minus one (divider counts 0 to 4, five cycles)
  localparam logic [7:0] SCK_HALF = 8'h04;
  // Device byte phases
  typedef enum logic [2:0] {
    PH_OPCODE = 3'b000,
    PH_ADDR = 3'b001,
    PH_DUMMY = 3'b011,
    PH_OUT = 3'b010,
    PH_WDATA = 3'b110,
    PH_IGNORE = 3'b111
  } phase_type;
  // Host link states
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_LOW = 2'b01,
    HS_HIGH = 2'b11,
    HS_HOLD = 2'b10
  } host_state_type;
endpackage : sr_access_pkg

// File: include/sr_link_if.sv
/*
  Serial link carrier between host controller and status-register device.
  Serial output is resolved here from the device's enable.
*/
`timescale 1ns/10ps
interface sr_link_if;
  logic sck; // Serial clock from host
  logic cs_n; // Chip select, active low
  logic mosi; // Host to device data
  logic miso_o; // Device output value
  logic miso_oe; // Device drives output
  logic miso; // Resolved line, pulled high when idle
  assign miso = miso_oe ? miso_o : 1'b1;
  modport device (input sck, input cs_n, input mosi, output miso_o, output miso_oe);
  modport host (output sck, output cs_n, output mosi, input miso);
endinterface : sr_link_if

// File: src/sync_two.sv
/*
  Two flip-flop synchroniser for a bit from another clock domain.
  Assumes the destination clock is much faster than the input changes.
*/
`timescale 1ns/10ps
module sync_two #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_async,
  output logic o_sync
);
  logic meta_reg; // First stage, read only by second
  // Two stage capture
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= RESET_VALUE;
      o_sync <= RESET_VALUE;
    end else if (i_ce) begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule : sync_two

// File: src/sr_device.sv
/*
  Status-register command device: indirect read (65h), direct writes
  (01h/31h/11h), write enables (06h, 50h), five status registers.
  Assumes link pins arrive asynchronously; serial clock mode 0.
*/
`timescale 1ns/10ps
// Operation
// - 65h plus address reads status register
// - Opcode eight clocks, MSB first, chip selected
// - Read address one byte, A7 first
// - Dummy byte on clocks 16 to 23
// - Data out from clock 24, MSB first
// - Address increments after each output byte
// - Addresses 6 to 255 give undefined data
// - Address wraps FFh to 00h
// - Release ends read, output floats
// - 01h/31h/11h write registers one to three
// - 50h enables only the next write
// - 06h sets write-enable latch before write
// - Write data eight clocks, MSB first
// - Release after write clears write-enable latch
// - Host sends full write before release
// - Unaligned release aborts write, nothing changes
// - Second byte after 01h goes register two
// - Host sends one byte for register one
module sr_device (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  sr_link_if.device link,
  output logic [39:0] o_status,
  output logic o_busy
);
  import sr_access_pkg::*;
  logic sck_s; // Synchronised serial clock
  logic cs_n_s; // Synchronised chip select
  logic mosi_s; // Synchronised input data
  logic sck_d_reg; // Delayed clock for edges
  logic [7:0] sr_reg [1:5]; // Status registers
  logic [7:0] shift_reg; // Incoming byte
  logic [2:0] bit_reg; // Bit within byte
  phase_type phase_reg; // Byte phase
  logic [7:0] opcode_reg; // Current opcode
  logic [7:0] addr_reg; // Read address
  logic [7:0] out_reg; // Outgoing byte
  logic [1:0] wcount_reg; // Data bytes taken
  logic [7:0] wdata_reg [0:1]; // Write data bytes
  logic [7:0] next_byte; // Register byte one below the read pointer
  logic prev_vol_reg; // Last frame was 50h
  logic miso_reg; // Output bit
  logic miso_oe_reg; // Output enable
  logic rise; // Serial clock rising
  logic fall; // Serial clock falling
  logic [7:0] byte_in; // Byte completed now
  logic byte_done; // Last bit of byte
  logic cs_rel_reg; // Chip select was low
  // Read a register by address, undefined outside range
  function automatic logic [7:0] sr_read(input logic [7:0] a, input logic [39:0] s);
    if (a >= IDX_SR_ONE && a <= IDX_SR_FIVE) begin
      sr_read = s[(a - 8'h01) * 8 +: 8];
    end else begin
      sr_read = SR_UNDEF;
    end
  endfunction : sr_read
  sync_two #(.RESET_VALUE(1'b0)) u_sck (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce), .i_async(link.sck), .o_sync(sck_s));
  sync_two #(.RESET_VALUE(1'b1)) u_cs (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce), .i_async(link.cs_n), .o_sync(cs_n_s));
  sync_two #(.RESET_VALUE(1'b0)) u_mosi (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce), .i_async(link.mosi), .o_sync(mosi_s));
  // Edge detection
  assign rise = sck_s & ~sck_d_reg & ~cs_n_s;
  assign fall = ~sck_s & sck_d_reg & ~cs_n_s;
  assign byte_in = {shift_reg[6:0], mosi_s};
  assign byte_done = rise && (bit_reg == BIT_LAST);
  assign link.miso_o = miso_reg;
  assign link.miso_oe = miso_oe_reg;
  // Byte to send; the pointer already runs one ahead of it
  assign next_byte = sr_read(addr_reg - 8'h01, o_status);
  // Flat view of registers
  always_comb begin
    o_status = {sr_reg[5], sr_reg[4], sr_reg[3], sr_reg[2], sr_reg[1]};
  end
  // Clock delay and chip select history
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sck_d_reg <= 1'b0;
      cs_rel_reg <= 1'b0;
      o_busy <= 1'b0;
    end else if (i_ce) begin
      sck_d_reg <= sck_s;
      cs_rel_reg <= ~cs_n_s;
      o_busy <= ~cs_n_s;
    end
  end
  // Input shifter, MSB first
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      shift_reg <= 8'h00;
      bit_reg <= 3'h0;
    end else if (i_ce) begin
      if (cs_n_s) begin
        bit_reg <= 3'h0;
      end else if (rise) begin
        shift_reg <= byte_in;
        bit_reg <= bit_reg + 3'h1;
      end
    end
  end
  // Byte phase sequencing
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_reg <= PH_OPCODE;
      opcode_reg <= 8'h00;
      addr_reg <= 8'h00;
      wcount_reg <= 2'h0;
      wdata_reg[0] <= 8'h00;
      wdata_reg[1] <= 8'h00;
    end else if (i_ce) begin
      if (cs_n_s) begin
        phase_reg <= PH_OPCODE;
        wcount_reg <= 2'h0;
      end else if (byte_done) begin
        case (phase_reg)
          PH_OPCODE: begin
            opcode_reg <= byte_in;
            if (byte_in == OP_READ_INDIRECT) begin
              phase_reg <= PH_ADDR;
            end else if (byte_in == OP_WRITE_SR1 || byte_in == OP_WRITE_SR2 ||
                         byte_in == OP_WRITE_SR3) begin
              phase_reg <= PH_WDATA;
            end else begin
              phase_reg <= PH_IGNORE;
            end
          end
          PH_ADDR: begin
            addr_reg <= byte_in;
            phase_reg <= PH_DUMMY;
          end
          PH_DUMMY: begin
            phase_reg <= PH_OUT;
            addr_reg <= addr_reg + 8'h01;
          end
          PH_OUT: begin
            addr_reg <= addr_reg + 8'h01;
          end
          PH_WDATA: begin
            if (wcount_reg != 2'h3) begin
              wcount_reg <= wcount_reg + 2'h1;
            end
            if (wcount_reg < 2'h2) begin
              wdata_reg[wcount_reg[0]] <= byte_in;
            end
          end
          default: begin
            phase_reg <= PH_IGNORE;
          end
        endcase
      end
    end
  end
  // Serial output, load on falling edge ahead of each data bit
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      out_reg <= 8'h00;
      miso_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
    end else if (i_ce) begin
      if (cs_n_s) begin
        miso_oe_reg <= 1'b0;
      end else if (fall && (phase_reg == PH_OUT)) begin
        miso_oe_reg <= 1'b1;
        if (bit_reg == 3'h0) begin
          // Address already points one past the byte to send
          out_reg <= {next_byte[6:0], 1'b0};
          miso_reg <= next_byte[7];
        end else begin
          miso_reg <= out_reg[7];
          out_reg <= {out_reg[6:0], 1'b0};
        end
      end
    end
  end
  // Enables and register update on release
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 1; i <= 5; i++) begin
        sr_reg[i] <= SR_RESET;
      end
      prev_vol_reg <= 1'b0;
    end else if (i_ce) begin
      if (cs_n_s && cs_rel_reg) begin
        // Frame just ended
        prev_vol_reg <= 1'b0;
        if (bit_reg == 3'h0 && phase_reg == PH_IGNORE && opcode_reg == OP_WRITE_ENABLE) begin
          sr_reg[1][WEL_BIT] <= 1'b1;
        end
        if (bit_reg == 3'h0 && phase_reg == PH_IGNORE && opcode_reg == OP_VOLATILE_WE) begin
          prev_vol_reg <= 1'b1;
        end
        if (phase_reg == PH_WDATA) begin
          if (bit_reg == 3'h0 && wcount_reg != 2'h0 &&
              (prev_vol_reg || sr_reg[1][WEL_BIT])) begin
            case (opcode_reg)
              OP_WRITE_SR1: begin
                sr_reg[1] <= wdata_reg[0];
                if (wcount_reg >= 2'h2) begin
                  sr_reg[2] <= wdata_reg[1];
                end
              end
              OP_WRITE_SR2: sr_reg[2] <= wdata_reg[0];
              OP_WRITE_SR3: sr_reg[3] <= wdata_reg[0];
              default: sr_reg[3] <= sr_reg[3];
            endcase
            sr_reg[1][WEL_BIT] <= 1'b0;
          end
        end
      end
    end
  end
endmodule : sr_device

// File: src/sr_host.sv
/*
  Host controller: AXI4-Lite slave registers drive a byte-wise serial
  master. Software writes a byte with CTRL start; last flag releases select.
  Assumes the device end samples on rising serial clock.
*/
`timescale 1ns/10ps
module sr_host (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [3:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [3:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  sr_link_if.host link
);
  import sr_access_pkg::*;
  host_state_type state_reg; // Link state
  logic [7:0] tx_reg; // Byte to send
  logic [7:0] rx_reg; // Byte received
  logic last_reg; // Release select after byte
  logic [2:0] bit_reg; // Bit counter
  logic [7:0] div_reg; // Clock divider
  logic [3:0] awaddr_reg; // Held write address
  logic [31:0] wdata_reg; // Held write data
  logic aw_have_reg; // Address taken
  logic w_have_reg; // Data taken
  logic miso_s; // Synchronised input
  logic start; // Start byte request
  logic sck_reg;
  logic cs_n_reg;
  logic mosi_reg;
  sync_two #(.RESET_VALUE(1'b1)) u_miso (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce), .i_async(link.miso), .o_sync(miso_s));
  assign link.sck = sck_reg;
  assign link.cs_n = cs_n_reg;
  assign link.mosi = mosi_reg;
  assign start = aw_have_reg && w_have_reg && !o_bvalid && awaddr_reg == OFS_CTRL &&
                 wdata_reg[CTRL_START] && state_reg == HS_IDLE;
  // Write channels, either order, response after both
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0;
      o_bvalid <= 1'b0;
      o_bresp <= 2'h0;
      tx_reg <= 8'h00;
      last_reg <= 1'b0;
    end else if (i_ce) begin
      if (i_awvalid && o_awready) begin
        awaddr_reg <= i_awaddr;
        aw_have_reg <= 1'b1;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        wdata_reg <= i_wdata;
        w_have_reg <= 1'b1;
        o_wready <= 1'b0;
      end
      if (aw_have_reg && w_have_reg && !o_bvalid && (state_reg == HS_IDLE ||
          awaddr_reg != OFS_CTRL)) begin
        o_bvalid <= 1'b1;
        o_bresp <= (awaddr_reg == OFS_CTRL || awaddr_reg == OFS_TXDATA) ? 2'h0 : 2'h2;
        if (awaddr_reg == OFS_TXDATA) begin
          tx_reg <= wdata_reg[7:0];
        end
        if (awaddr_reg == OFS_CTRL) begin
          last_reg <= wdata_reg[CTRL_LAST];
        end
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end
  // Read channel
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= 2'h0;
    end else if (i_ce) begin
      if (i_arvalid && o_arready) begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rresp <= 2'h0;
        case (i_araddr)
          OFS_STATUS: o_rdata <= {30'h0, ~cs_n_reg, state_reg != HS_IDLE};
          OFS_RXDATA: o_rdata <= {24'h0, rx_reg};
          OFS_TXDATA: o_rdata <= {24'h0, tx_reg};
          OFS_CTRL: o_rdata <= {30'h0, last_reg, 1'b0};
          default: begin
            o_rdata <= 32'h0;
            o_rresp <= 2'h2;
          end
        endcase
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end
  // Serial byte engine, mode 0, MSB first
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= HS_IDLE;
      sck_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      mosi_reg <= 1'b0;
      bit_reg <= 3'h0;
      div_reg <= 8'h00;
      rx_reg <= 8'h00;
    end else if (i_ce) begin
      case (state_reg)
        HS_IDLE: begin
          if (start) begin
            cs_n_reg <= 1'b0;
            mosi_reg <= tx_reg[7];
            bit_reg <= 3'h0;
            div_reg <= 8'h00;
            state_reg <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (div_reg == SCK_HALF) begin
            div_reg <= 8'h00;
            sck_reg <= 1'b1;
            state_reg <= HS_HIGH;
          end else begin
            div_reg <= div_reg + 8'h01;
          end
        end
        HS_HIGH: begin
          if (div_reg == SCK_HALF) begin
            div_reg <= 8'h00;
            sck_reg <= 1'b0;
            // Sample at the end of the high phase; the device answers
            // several cycles behind the pins, so the rising edge is too early
            rx_reg <= {rx_reg[6:0], miso_s};
            if (bit_reg == BIT_LAST) begin
              state_reg <= HS_HOLD;
            end else begin
              bit_reg <= bit_reg + 3'h1;
              mosi_reg <= tx_reg[3'h6 - bit_reg];
              state_reg <= HS_LOW;
            end
          end else begin
            div_reg <= div_reg + 8'h01;
          end
        end
        HS_HOLD: begin
          if (div_reg == SCK_HALF) begin
            div_reg <= 8'h00;
            if (last_reg) begin
              cs_n_reg <= 1'b1;
            end
            state_reg <= HS_IDLE;
          end else begin
            div_reg <= div_reg + 8'h01;
          end
        end
        default: state_reg <= HS_IDLE;
      endcase
    end
  end
endmodule : sr_host

// File: dv/sr_link_properties.sv
/*
  Checker for the serial link between the host controller and the device.
  Assumes the reference clock samples every link edge.
*/
`timescale 1ns/10ps
module sr_link_properties (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe
);
  logic sck_reg; // Serial clock one cycle back
  logic [15:0] rise_cnt_reg; // Serial clock rises in this frame

  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  // Delayed serial clock for edge finding
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sck_reg <= 1'b0;
    end else begin
      sck_reg <= sck;
    end
  end

  // Rise counter, cleared while deselected
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rise_cnt_reg <= 16'h0000;
    end else if (cs_n) begin
      rise_cnt_reg <= 16'h0000;
    end else if (sck && !sck_reg) begin
      rise_cnt_reg <= rise_cnt_reg + 16'h0001;
    end
  end

  sck_idle_low_a: assert property (cs_n |-> !sck)
    else $error("serial clock high while deselected");
  first_clock_a: assert property ($fell(cs_n) |-> ##[1:40] $rose(sck))
    else $error("no serial clock after select");
  mosi_stable_a: assert property (sck |-> $stable(mosi))
    else $error("host data moved while clock high");
  sck_high_a: assert property ($rose(sck) |-> sck [*4])
    else $error("serial clock high phase too short");
  byte_release_a: assert property ($rose(cs_n) |-> rise_cnt_reg[2:0] == 3'h0)
    else $error("host released select mid byte");
  drive_late_a: assert property ($rose(miso_oe) |-> rise_cnt_reg >= 16'h0018)
    else $error("device drove output before clock 24");
  float_after_a: assert property ($rose(cs_n) |-> ##[0:6] !miso_oe)
    else $error("device output not released");
  miso_hold_a: assert property ((sck && $past(sck) && miso_oe && $past(miso_oe))
    |-> $stable(miso_o))
    else $error("device data moved while clock high");
endmodule : sr_link_properties

// File: dv/tb_top.sv
/*
  Testbench: AXI4-Lite master tasks drive the host, which reaches one device;
  a second device sits on a link driven bit by bit here for faults.
  Assumes a 50 MHz reference clock.
*/
`timescale 1ns/10ps
module tb_top;
  import sr_access_pkg::*;
  logic i_ref_clk = 1'b0; // Reference clock
  logic i_rst = 1'b1; // Reset, active high
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, busy;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [39:0] status, status_b; // Device register images
  logic [7:0] rxq[$]; // Bytes received in last frame
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;

  sr_link_if sr_link_if_inst();
  sr_link_if fault_link();
  sr_host sr_host_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(1'b1),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .link(sr_link_if_inst.host));
  sr_device sr_device_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(1'b1),
    .link(sr_link_if_inst.device), .o_status(status), .o_busy(busy));
  sr_device sr_device_inst_b (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(1'b1),
    .link(fault_link.device), .o_status(status_b), .o_busy());
  sr_link_properties sr_link_properties_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .sck(sr_link_if_inst.sck), .cs_n(sr_link_if_inst.cs_n), .mosi(sr_link_if_inst.mosi),
    .miso_o(sr_link_if_inst.miso_o), .miso_oe(sr_link_if_inst.miso_oe));

  // Clock and hang guard
  always #10 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end

  // Compare and count
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Verdict and end of run
  task automatic results();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // One AXI write, held until each channel is taken
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge i_ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge i_ref_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    r = bresp;
  endtask : axi_write

  // One AXI read
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge i_ref_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : axi_read

  // Whole frame through the host, bytes received land in rxq
  task automatic frame(input logic [7:0] tx[$]);
    logic [31:0] rd, ctl;
    logic [1:0] resp;
    rxq = {};
    foreach (tx[i]) begin
      ctl = 32'h0;
      ctl[CTRL_START] = 1'b1;
      ctl[CTRL_LAST] = (i == tx.size() - 1);
      axi_write(OFS_TXDATA, {24'h0, tx[i]}, resp);
      axi_write(OFS_CTRL, ctl, resp);
      check(resp, 2'b00);
      rd = 32'h1;
      while (rd[0] !== 1'b0) axi_read(OFS_STATUS, rd, resp);
      check(rd[1], i != tx.size() - 1);
      axi_read(OFS_RXDATA, rd, resp);
      rxq.push_back(rd[7:0]);
    end
    repeat (4) @(posedge i_ref_clk);
    while (busy !== 1'b0) @(posedge i_ref_clk);
    repeat (4) @(posedge i_ref_clk);
  endtask : frame

  // Bit-level frame on the fault link, 1 to 24 bits
  task automatic bb_frame(input logic [23:0] bits, input int n);
    @(posedge i_ref_clk);
    fault_link.cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      fault_link.mosi <= bits[i]; // MSB first
      repeat (4) @(posedge i_ref_clk);
      fault_link.sck <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      fault_link.sck <= 1'b0;
    end
    repeat (4) @(posedge i_ref_clk);
    fault_link.cs_n <= 1'b1;
    fault_link.mosi <= ~fault_link.mosi; // Released line does not hold
    repeat (12) @(posedge i_ref_clk);
  endtask : bb_frame

  // Reset image, host register map and unmapped host address
  task automatic t_reset();
    logic [31:0] rd;
    logic [1:0] resp;
    check(status, {5{SR_RESET}});
    axi_read(4'h2, rd, resp);
    check(resp, 2'b10);
    check(rd, 32'h0);
    axi_write(OFS_TXDATA, 32'h0000005A, resp);
    check(resp, 2'b00);
    axi_read(OFS_TXDATA, rd, resp);
    check(rd, 32'h0000005A);
    axi_read(OFS_STATUS, rd, resp);
    check(rd, 32'h0);
    axi_read(OFS_CTRL, rd, resp);
    check(rd, 32'h0);
    axi_write(4'h2, 32'h0, resp);
    check(resp, 2'b10);
  endtask : t_reset

  // Latch-enabled writes of all three direct opcodes
  task automatic t_direct();
    logic [7:0] ops[3] = '{OP_WRITE_SR1, OP_WRITE_SR2, OP_WRITE_SR3};
    logic [7:0] vals[3] = '{8'h5C, 8'hA5, 8'h3C};
    for (int k = 0; k < 3; k++) begin
      frame({OP_WRITE_ENABLE});
      check(status[WEL_BIT], 1'b1);
      frame({ops[k], vals[k]});
      check(status[8*k +: 8], vals[k]);
      check(status[WEL_BIT], 1'b0);
    end
  endtask : t_direct

  // Missing, volatile and one-shot enables, opcode without data
  task automatic t_guard();
    frame({OP_WRITE_SR3, 8'hFF});
    check(status[23:16], 8'h3C);
    frame({OP_VOLATILE_WE});
    check(status[WEL_BIT], 1'b0);
    frame({OP_WRITE_SR3, 8'h81});
    check(status[23:16], 8'h81);
    frame({OP_WRITE_SR3, 8'h42});
    check(status[23:16], 8'h81);
    frame({OP_WRITE_ENABLE});
    frame({OP_WRITE_SR2});
    check(status[15:8], 8'hA5);
    frame({OP_WRITE_ENABLE});
    frame({OP_WRITE_SR1, 8'h18, 8'h7E});
    check(status[15:0], 16'h7E18);
  endtask : t_guard

  // Indirect reads: sequence, undefined area, wrap
  task automatic t_read();
    logic [39:0] exp;
    exp = {8'h00, 8'h00, 8'h81, 8'h7E, 8'h18};
    frame({OP_READ_INDIRECT, IDX_SR_ONE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00});
    check(rxq[2], 8'hFF);
    for (int k = 0; k < 5; k++) check(rxq[3 + k], exp[8*k +: 8]);
    check({rxq[8], rxq[9]}, {2{SR_UNDEF}});
    frame({OP_READ_INDIRECT, IDX_SR_FIVE, 8'h00, 8'h00, 8'h00});
    check(rxq[3], exp[39:32]);
    check(rxq[4], SR_UNDEF);
    frame({OP_READ_INDIRECT, 8'hFE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    check(rxq[6], exp[7:0]);
  endtask : t_read

  // Unaligned release on the fault link, then a clean write
  task automatic t_fault();
    bb_frame({16'h0, OP_WRITE_ENABLE}, 8);
    check(status_b[WEL_BIT], 1'b1);
    bb_frame({12'h0, OP_WRITE_SR2, 4'hA}, 12);
    check(status_b[15:8], 8'h00);
    bb_frame({16'h0, OP_WRITE_ENABLE}, 8);
    bb_frame({8'h0, OP_WRITE_SR2, 8'hC3}, 16);
    check(status_b[15:8], 8'hC3);
  endtask : t_fault

  // Main sequence
  initial begin
    fault_link.sck = 1'b0;
    fault_link.cs_n = 1'b1;
    fault_link.mosi = 1'b0;
    repeat (8) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_reset();
    t_direct();
    t_guard();
    t_read();
    t_fault();
    results();
  end
endmodule : tb_top
